// File: hdl/flash_prefetch_cache_control.sv
// Flash prefetch cache controller: lookup, prediction, fills, flush, registers
`default_nettype none

module flash_prefetch_cache_control #(
    parameter int LINES = 16
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire flash_cache_pkg::reg_bus_t reg_bus,
    output logic [31:0] reg_rdata,
    input wire flash_cache_pkg::cpu_req_t cpu,
    output logic cpu_ready,
    output logic cpu_rvalid,
    output logic [31:0] cpu_rdata,
    output logic flash_rd,
    output logic [31:0] flash_addr,
    input wire logic [127:0] flash_rdata,
    input wire logic flash_prog_busy,
    input wire logic flash_write_done,
    input wire logic sleep_req,
    input wire logic idle_req,
    output logic clk_stop_ok
);

    localparam int IW = $clog2(LINES);

    // ****************************************
    // Elaboration check
    // ****************************************
    if (LINES != 16) begin : g_bad
        $error("Data line allocation decode serves exactly 16 lines");
    end

    // ****************************************
    // Storage
    // ****************************************
    logic [31:0] ctrl_reg;                // Cache control register
    logic [IW-1:0] index_reg;             // Line picked for tag access
    logic [LINES-1:0][27:0] tag_reg;      // Line address tags
    logic [LINES-1:0] valid_reg;          // Line valid bits
    logic [LINES-1:0] lock_reg;           // Line lock bits
    logic [127:0] data_mem [LINES];       // Line contents

    // Engine state
    flash_cache_pkg::eng_state_t state_reg;
    logic [27:0] flash_line_reg;          // Line being read from flash
    logic [2:0] ws_cnt_reg;               // Remaining wait states
    logic owe_reg;                        // CPU waits for a flash line
    logic [27:0] req_line_reg;            // Pending request line
    logic [1:0] req_word_reg;             // Pending request word
    logic req_instr_reg;                  // Pending request is a fetch
    logic req_cache_reg;                  // Pending request cacheable
    logic [127:0] pbuf_data_reg;          // Prefetch buffer contents
    logic [27:0] pbuf_line_reg;           // Prefetch buffer tag
    logic pbuf_valid_reg;                 // Prefetch buffer holds a line
    logic cpu_ready_reg;
    logic cpu_rvalid_reg;
    logic [31:0] cpu_rdata_reg;
    logic flash_rd_reg;
    logic clk_stop_ok_reg;
    logic [31:0] reg_rdata_reg;

    // ****************************************
    // Decode helpers
    // ****************************************
    // Lines given to constant data for each allocation code
    function automatic logic is_data_line(input int idx, input logic [1:0] dcsz);
        case (dcsz)
            2'b01: is_data_line = (idx == 15);
            2'b10: is_data_line = (idx >= 14);
            2'b11: is_data_line = (idx >= 12);
            default: is_data_line = 1'b0;
        endcase
    endfunction : is_data_line

    // Prefetch allowed for this attribute: bit 0 cacheable, bit 1 non-cacheable
    function automatic logic pf_on(input logic [1:0] field, input logic cacheable);
        pf_on = cacheable ? field[0] : field[1];
    endfunction : pf_on

    // 32-bit word of a 128-bit line
    function automatic logic [31:0] pick_word(input logic [127:0] line, input logic [1:0] w);
        pick_word = line[32*w +: 32];
    endfunction : pick_word

    // ****************************************
    // Control fields and lookup
    // ****************************************
    logic [2:0] ws;         // Flash wait states
    logic [1:0] pf_field;   // Prefetch enable field
    logic [1:0] dcsz;       // Data line allocation
    logic coh_all;          // Flush everything on flash write
    assign ws = ctrl_reg[flash_cache_pkg::WS_LSB +: 3]; // [R23]
    assign pf_field = ctrl_reg[flash_cache_pkg::PF_LSB +: 2]; // [R24]
    assign dcsz = ctrl_reg[flash_cache_pkg::DCSZ_LSB +: 2];
    assign coh_all = ctrl_reg[flash_cache_pkg::COH_BIT];

    logic [27:0] cpu_line;  // Address with bits 3:0 dropped
    assign cpu_line = cpu.addr[31:4];                               // [R22]

    logic m_hit;
    logic [IW-1:0] m_idx;
    line_tag_match #(.LINES(LINES), .TAGW(28)) u_match (
        .tags(tag_reg),
        .valid(valid_reg),
        .line_addr(cpu_line),
        .hit(m_hit),
        .hit_idx(m_idx)
    );

    logic take;        // Request accepted this cycle
    logic hit;         // Cacheable cache hit
    logic pbuf_hit;    // Prefetch buffer hit
    logic inflight;    // Request for the line under prefetch
    logic done;        // Flash data due this cycle
    logic svc_flash;   // Flash data answers the CPU now
    logic svc_pbuf;    // Buffer answers a cache miss now
    logic owe_next;
    logic want_pf;     // Accepted fetch asks for prediction
    logic [27:0] next_line;
    assign take = cpu.valid && cpu_ready_reg;
    assign hit = m_hit && cpu.cacheable;                            // [R18]
    assign pbuf_hit = pbuf_valid_reg && (pbuf_line_reg == cpu_line);
    assign inflight = (state_reg == flash_cache_pkg::ST_PREF) && cpu.instr
        && (flash_line_reg == cpu_line);
    assign done = flash_rd_reg && (ws_cnt_reg == 3'h0); // [R23]
    assign svc_flash = done && (owe_reg || (take && inflight));
    assign svc_pbuf = take && !hit && pbuf_hit;
    assign want_pf = cpu.instr && pf_on(pf_field, cpu.cacheable) && !sleep_req; // [R9] [R24]
    assign next_line = cpu_line + 28'h000_0001; // [R2]

    // Outstanding-request tracking feeds the ready flop
    always_comb begin
        owe_next = owe_reg;
        if (svc_flash) begin
            owe_next = 1'b0;
        end else if (take && !hit && !pbuf_hit) begin
            owe_next = 1'b1;
        end
    end

    // ****************************************
    // Fill selection
    // ****************************************
    logic fill_instr;       // Filling request is a fetch
    logic fill_cache;       // Filling request cacheable
    logic [27:0] fill_line;
    logic [127:0] fill_data;
    logic [LINES-1:0] allow;
    logic victim_ok;
    logic [IW-1:0] victim_idx;
    logic fill_en;
    assign fill_instr = take ? cpu.instr : req_instr_reg;
    assign fill_cache = take ? cpu.cacheable : req_cache_reg;
    assign fill_line = svc_pbuf ? cpu_line : flash_line_reg;
    assign fill_data = svc_pbuf ? pbuf_data_reg : flash_rdata;

    // Locked lines and lines of the other kind are never victims
    for (genvar i = 0; i < LINES; i++) begin : g_allow
        assign allow[i] = !(valid_reg[i] && lock_reg[i])            // [R25] [R12]
            && (fill_instr ? !is_data_line(i, dcsz) : is_data_line(i, dcsz));
    end

    // Non-cacheable traffic never fills; flush in the same cycle blocks a stale fill
    assign fill_en = (svc_pbuf || svc_flash) && fill_cache && victim_ok // [R5] [R6] [R7]
        && !flash_write_done;

    lru_order #(.LINES(LINES)) u_lru (
        .core_clk(core_clk),
        .rstn(rstn),
        .touch((take && hit) || fill_en),                          // [R7]
        .touch_idx((take && hit) ? m_idx : victim_idx),
        .allow(allow),
        .victim_ok(victim_ok),
        .victim_idx(victim_idx)
    );

    // ****************************************
    // Fetch engine
    // ****************************************
    // Demand reads, prediction, redirection and aborts
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= flash_cache_pkg::ST_IDLE;
            flash_line_reg <= '0;
            ws_cnt_reg <= '0;
            flash_rd_reg <= 1'b0;
            req_line_reg <= '0;
            req_word_reg <= '0;
            req_instr_reg <= 1'b0;
            req_cache_reg <= 1'b0;
            pbuf_data_reg <= '0;
            pbuf_line_reg <= '0;
            pbuf_valid_reg <= 1'b0;
            cpu_rvalid_reg <= 1'b0;
            cpu_rdata_reg <= '0;
        end else begin
            cpu_rvalid_reg <= 1'b0;
            if (flash_rd_reg && ws_cnt_reg != 3'h0) begin
                ws_cnt_reg <= ws_cnt_reg - 3'h1;
            end
            // Data arrives: flash read ends, prefetched line lands in buffer
            if (done) begin
                flash_rd_reg <= 1'b0;                               // [R8]
                state_reg <= flash_cache_pkg::ST_IDLE;
                if (state_reg == flash_cache_pkg::ST_PREF) begin
                    pbuf_data_reg <= flash_rdata;                   // [R3]
                    pbuf_line_reg <= flash_line_reg;
                    pbuf_valid_reg <= 1'b1;
                end
            end
            if (take) begin
                req_line_reg <= cpu_line;
                req_word_reg <= cpu.addr[3:2];
                req_instr_reg <= cpu.instr;
                req_cache_reg <= cpu.cacheable;
            end
            if (svc_flash) begin
                // Flash line answers the waiting CPU, then predict onward
                cpu_rvalid_reg <= 1'b1;
                cpu_rdata_reg <= pick_word(flash_rdata, take ? cpu.addr[3:2] : req_word_reg);
                if (fill_instr && pf_on(pf_field, fill_cache) && !sleep_req) begin // [R1] [R2]
                    state_reg <= flash_cache_pkg::ST_PREF;
                    flash_line_reg <= flash_line_reg + 28'h000_0001;
                    flash_rd_reg <= 1'b1;
                    ws_cnt_reg <= ws;
                end
            end else if (sleep_req && !owe_reg && !take) begin
                // Sleep drops speculation at once
                state_reg <= flash_cache_pkg::ST_IDLE;              // [R19]
                flash_rd_reg <= 1'b0;
            end else if (take && (hit || pbuf_hit)) begin
                // Zero-wait answer from cache line or buffer
                cpu_rvalid_reg <= 1'b1;
                cpu_rdata_reg <= pick_word(hit ? data_mem[m_idx] : pbuf_data_reg,
                    cpu.addr[3:2]);
                if (want_pf && !(state_reg == flash_cache_pkg::ST_PREF
                    && flash_line_reg == next_line)) begin          // [R1] [R2]
                    state_reg <= flash_cache_pkg::ST_PREF;
                    flash_line_reg <= next_line;
                    flash_rd_reg <= 1'b1;
                    ws_cnt_reg <= ws;
                end
            end else if (take && !inflight) begin
                // Miss: redirect or abort any prediction, read the wanted line
                state_reg <= flash_cache_pkg::ST_DEMAND;            // [R4] [R6] [R10]
                flash_line_reg <= cpu_line;
                flash_rd_reg <= 1'b1;
                ws_cnt_reg <= ws;
            end
            if (flash_write_done) begin
                pbuf_valid_reg <= 1'b0;                             // [R14] [R15]
            end
        end
    end

    // ****************************************
    // Tag, valid and lock state
    // ****************************************
    // Flush on flash write, then fills, then software tag writes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tag_reg <= '0;                                          // [R16]
            valid_reg <= '0;
            lock_reg <= '0;
        end else if (flash_write_done) begin
            if (coh_all) begin
                tag_reg <= '0;                                      // [R14]
                valid_reg <= '0;
                lock_reg <= '0;
            end else begin
                valid_reg <= valid_reg & lock_reg;                  // [R15]
            end
        end else if (fill_en) begin
            tag_reg[victim_idx] <= fill_line;                       // [R5] [R6]
            valid_reg[victim_idx] <= 1'b1;
        end else if (reg_bus.wr && reg_bus.addr == flash_cache_pkg::OFF_TAG) begin
            // Breakpoint lines are locked and later invalidated here
            tag_reg[index_reg] <= reg_bus.wdata[31:flash_cache_pkg::TAG_LSB]; // [R21]
            valid_reg[index_reg] <= reg_bus.wdata[flash_cache_pkg::TAG_VALID_BIT];
            lock_reg[index_reg] <= reg_bus.wdata[flash_cache_pkg::TAG_LOCK_BIT];
        end
    end

    // Line contents, written only by fills
    always_ff @(posedge core_clk) begin
        if (fill_en) begin
            data_mem[victim_idx] <= fill_data;
        end
    end

    // ****************************************
    // Handshake and power outputs
    // ****************************************
    // Ready drops while owed, programming or sleeping
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            owe_reg <= 1'b0;
            cpu_ready_reg <= 1'b0;
            clk_stop_ok_reg <= 1'b0;
        end else begin
            owe_reg <= owe_next;
            cpu_ready_reg <= !owe_next && !flash_prog_busy && !sleep_req; // [R13] [R19]
            clk_stop_ok_reg <= (idle_req || sleep_req) && !owe_reg // [R20]
                && !flash_rd_reg && state_reg == flash_cache_pkg::ST_IDLE;
        end
    end

    // ****************************************
    // Register bus
    // ****************************************
    // Software writes to control and index
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= flash_cache_pkg::CTRL_RESET;                // [R16]
            index_reg <= '0;
        end else if (reg_bus.wr) begin
            if (reg_bus.addr == flash_cache_pkg::OFF_CTRL) begin
                ctrl_reg <= reg_bus.wdata & flash_cache_pkg::CTRL_WMASK;
            end else if (reg_bus.addr == flash_cache_pkg::OFF_INDEX) begin
                index_reg <= reg_bus.wdata[IW-1:0];
            end
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_reg <= '0;
        end else begin
            reg_rdata_reg <= '0;
            if (reg_bus.rd) begin
                if (reg_bus.addr == flash_cache_pkg::OFF_CTRL) begin
                    reg_rdata_reg <= ctrl_reg;
                end else if (reg_bus.addr == flash_cache_pkg::OFF_INDEX) begin
                    reg_rdata_reg <= {{(32 - IW){1'b0}}, index_reg};
                end else if (reg_bus.addr == flash_cache_pkg::OFF_TAG) begin
                    reg_rdata_reg <= {tag_reg[index_reg], valid_reg[index_reg],
                        lock_reg[index_reg], 2'b00};
                end else if (reg_bus.addr == flash_cache_pkg::OFF_STATUS) begin
                    reg_rdata_reg <= {28'h000_0000, state_reg, owe_reg, pbuf_valid_reg};
                end
            end
        end
    end

    assign reg_rdata = reg_rdata_reg;
    assign cpu_ready = cpu_ready_reg;
    assign cpu_rvalid = cpu_rvalid_reg;
    assign cpu_rdata = cpu_rdata_reg;
    assign flash_rd = flash_rd_reg;
    assign flash_addr = {flash_line_reg, 4'h0}; // [R22]
    assign clk_stop_ok = clk_stop_ok_reg;

endmodule : flash_prefetch_cache_control

`default_nettype wire

// File: hdl/flash_cache_pkg.sv
// Constants, types and register map of the flash prefetch cache controller
//
// Overview of operation
// R1: Cacheable prefetch returns next line into LRU slot; code lands it in the prefetch buffer, copied to the LRU slot on a buffer hit
// R2: Prediction starts on first fetch, next aligned line
// R3: Linear code finds next line ready in time
// R4: Mismatching CPU address redirects the flash read
// R5: Buffer hit copies line and tag, marks MRU
// R6: Double miss reads flash, fills LRU line
// R7: Non-cacheable prefetch uses buffer only, cache untouched
// R8: Prefetched data held on flash output briefly
// R9: Only instruction fetches trigger prediction
// R10: Data load aborts prefetch; prediction awaits next fetch
// R11: Read-miss fills use pseudo-LRU victim choice; code picks victims from a full LRU rank order
// R12: Locking and data lines steer victim, not order
// R13: Flash programming stalls all cache service
// R14: Flush-all flash write clears every line fully
// R15: Otherwise flash write invalidates only unlocked lines
// R16: Reset: lines invalid, unlocked, instruction, masks cleared
// R17: Reset LRU order sequential, line 0 oldest
// R18: Behaviour follows control register and coherency attribute
// R19: Sleep disables prefetching, module clock stoppable
// R20: Idle finishes outstanding prefetch before clock gating
// R21: Debug mode behaves like normal operation
// R22: Sixteen 128-bit lines, address bits 3:0 dropped
// R23: Miss waits programmed flash wait states
// R24: Two-bit field selects speculative next-line fetch
// R25: Locked means valid and lock both set
`default_nettype none

package flash_cache_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;   // Cache control register
    localparam logic [7:0] OFF_INDEX = 8'h04;  // Line index for tag access
    localparam logic [7:0] OFF_TAG = 8'h08;    // Line tag register of indexed line
    localparam logic [7:0] OFF_STATUS = 8'h0C; // Engine status

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int WS_LSB = 0;       // Flash wait states, 3 bits
    localparam int PF_LSB = 4;       // Prefetch enable field, 2 bits
    localparam int DCSZ_LSB = 8;     // Data line allocation, 2 bits
    localparam int COH_BIT = 16;     // Coherency flush all
    localparam int TAG_VALID_BIT = 3; // Line valid bit
    localparam int TAG_LOCK_BIT = 2;  // Line lock bit
    localparam int TAG_LSB = 4;      // Line address tag, bits 31:4
    localparam logic [31:0] CTRL_RESET = 32'h0000_0007;
    localparam logic [31:0] CTRL_WMASK = 32'h0001_0337;
    localparam int FLASH_HOLD_MAX = 3; // Cycles prefetched data may sit on flash output

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,   // No flash access
        ST_DEMAND = 2'b01, // CPU-requested flash read
        ST_PREF = 2'b10    // Speculative next-line read
    } eng_state_t;

    typedef struct packed {
        logic valid;       // CPU request strobe
        logic [31:0] addr; // Byte address
        logic instr;       // Instruction fetch, else data load
        logic cacheable;   // Coherency attribute
    } cpu_req_t;

    typedef struct packed {
        logic [7:0] addr;   // Register byte offset
        logic [31:0] wdata; // Write data
        logic wr;           // Write strobe
        logic rd;           // Read strobe
    } reg_bus_t;

endpackage : flash_cache_pkg

`default_nettype wire

// File: hdl/line_tag_match.sv
// Fully associative tag compare over all cache lines
`default_nettype none

module line_tag_match #(
    parameter int LINES = 16,
    parameter int TAGW = 28
) (
    input wire logic [LINES-1:0][TAGW-1:0] tags,
    input wire logic [LINES-1:0] valid,
    input wire logic [TAGW-1:0] line_addr,
    output logic hit,
    output logic [$clog2(LINES)-1:0] hit_idx
);

    logic [LINES-1:0] match; // One bit per matching line

    // ****************************************
    // Per-line compare
    // ****************************************
    for (genvar i = 0; i < LINES; i++) begin : g_cmp
        assign match[i] = valid[i] && (tags[i] == line_addr);
    end

    // Lowest matching line wins
    always_comb begin
        hit = 1'b0;
        hit_idx = '0;
        for (int i = LINES - 1; i >= 0; i--) begin
            if (match[i]) begin
                hit = 1'b1;
                hit_idx = i[$clog2(LINES)-1:0];
            end
        end
    end

endmodule : line_tag_match

`default_nettype wire

// File: hdl/lru_order.sv
// Recency order of cache lines and victim choice
`default_nettype none

module lru_order #(
    parameter int LINES = 16
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic touch,
    input wire logic [$clog2(LINES)-1:0] touch_idx,
    input wire logic [LINES-1:0] allow,
    output logic victim_ok,
    output logic [$clog2(LINES)-1:0] victim_idx
);

    localparam int IW = $clog2(LINES);
    logic [IW-1:0] rank_reg [LINES]; // 0 = least recently used

    // Touched line becomes newest, younger lines age by one
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < LINES; i++) begin
                rank_reg[i] <= i[IW-1:0]; // [R17]
            end
        end else if (touch) begin
            for (int i = 0; i < LINES; i++) begin
                if (i[IW-1:0] == touch_idx) begin
                    rank_reg[i] <= IW'(LINES - 1); // [R5]
                end else if (rank_reg[i] > rank_reg[touch_idx]) begin
                    rank_reg[i] <= rank_reg[i] - 1'b1;
                end
            end
        end
    end

    // Oldest permitted line; the mask never alters the order itself
    always_comb begin
        logic [IW-1:0] best;
        best = '1;
        victim_ok = 1'b0;
        victim_idx = '0;
        for (int i = 0; i < LINES; i++) begin
            if (allow[i] && (!victim_ok || rank_reg[i] < best)) begin // [R11] [R12]
                victim_ok = 1'b1;
                victim_idx = i[IW-1:0];
                best = rank_reg[i];
            end
        end
    end

endmodule : lru_order

`default_nettype wire

// File: tb/flash_model.sv
// Behavioural program flash: each word of a line holds its own byte address
`default_nettype none
module flash_model (
    input wire logic flash_rd,
    input wire logic [31:0] flash_addr,
    output logic [127:0] flash_rdata
);
    logic [31:0] base; // Line address, low nibble dropped
    logic [127:0] line; // Line pattern, word 0 in bits 31:0
    assign base = {flash_addr[31:4], 4'h0};
    assign line = {base + 32'h0000_000C, base + 32'h0000_0008, base + 32'h0000_0004, base};
    // Inverted pattern when not read, so stale data never looks right
    assign flash_rdata = flash_rd ? line : ~line;
endmodule : flash_model
`default_nettype wire

// File: tb/flash_cache_chk.sv
// Port checker for the flash prefetch cache controller
`default_nettype none
module flash_cache_chk (
    input wire logic core_clk,
    input wire logic rstn,
    input wire flash_cache_pkg::reg_bus_t reg_bus,
    input wire logic [31:0] reg_rdata,
    input wire flash_cache_pkg::cpu_req_t cpu,
    input wire logic cpu_ready,
    input wire logic cpu_rvalid,
    input wire logic flash_rd,
    input wire logic [31:0] flash_addr,
    input wire logic flash_prog_busy,
    input wire logic sleep_req,
    input wire logic idle_req,
    input wire logic clk_stop_ok
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    chk_flash_align: assert property (flash_rd |-> flash_addr[3:0] == 4'h0)
        else $error("flash address not line aligned");
    chk_rdata_idle: assert property (!$past(reg_bus.rd) |-> reg_rdata == 32'h0000_0000)
        else $error("register read data outside read slot");
    chk_ctrl_mask: assert property (reg_bus.rd && reg_bus.addr == flash_cache_pkg::OFF_CTRL
        |=> (reg_rdata & ~flash_cache_pkg::CTRL_WMASK) == 32'h0000_0000)
        else $error("control read shows bits outside mask");
    chk_prog_stall: assert property ($past(flash_prog_busy) |-> !cpu_ready)
        else $error("request accepted during programming");
    chk_sleep_stop: assert property (sleep_req[*8] ##1 sleep_req[*8]
        |-> !flash_rd && clk_stop_ok) else $error("flash active or clock not stoppable in sleep");
    chk_idle_finish: assert property (idle_req && $past(flash_rd) |-> !clk_stop_ok)
        else $error("clock stop allowed with flash read running");
    chk_read_cause: assert property ($rose(flash_rd) |-> $past(cpu.valid && cpu_ready))
        else $error("flash read started without a request");
    chk_answer_bound: assert property (cpu.valid && cpu_ready |-> ##[1:18] cpu_rvalid)
        else $error("request not answered in time");
endmodule : flash_cache_chk
bind flash_prefetch_cache_control flash_cache_chk i_flash_cache_chk (.core_clk, .rstn,
    .reg_bus, .reg_rdata, .cpu, .cpu_ready, .cpu_rvalid, .flash_rd, .flash_addr,
    .flash_prog_busy, .sleep_req, .idle_req, .clk_stop_ok);
`default_nettype wire

// File: tb/flash_prefetch_cache_control_tb_top.sv
// Self-checking testbench of the flash prefetch cache controller
`default_nettype none
module flash_prefetch_cache_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rstn = 1'b0, cpu_ready, cpu_rvalid, flash_rd, clk_stop_ok;
    logic flash_prog_busy = 1'b0, flash_write_done = 1'b0, sleep_req = 1'b0, idle_req = 1'b0;
    flash_cache_pkg::reg_bus_t reg_bus = '0; // Register bus master side
    flash_cache_pkg::cpu_req_t cpu = '0; // CPU request side
    logic [31:0] reg_rdata, cpu_rdata, flash_addr;
    logic [127:0] flash_rdata;
    int fails = 0, compares = 0;
    initial forever #2.5 core_clk = ~core_clk;
    flash_prefetch_cache_control i_flash_prefetch_cache_control (.core_clk, .rstn, .reg_bus,
        .reg_rdata, .cpu, .cpu_ready, .cpu_rvalid, .cpu_rdata, .flash_rd, .flash_addr,
        .flash_rdata, .flash_prog_busy, .flash_write_done, .sleep_req, .idle_req, .clk_stop_ok);
    flash_model i_flash_model (.flash_rd, .flash_addr, .flash_rdata);
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    // One register write or read; a read is judged in the cycle after its strobe
    task automatic reg_acc(input logic [7:0] a, input logic w, input logic [31:0] d, e);
        reg_bus <= '{a, d, w, !w};
        @(posedge core_clk);
        reg_bus.wr <= 1'b0;
        reg_bus.rd <= 1'b0;
        @(posedge core_clk);
        if (!w) check("reg_rdata", e, reg_rdata);
    endtask : reg_acc
    // One CPU request; judges latency from take to answer and the word returned
    task automatic fetch(input logic [31:0] a, input logic ins, c, input logic [31:0] lat);
        logic [31:0] n;
        cpu <= '{1'b1, a, ins, c};
        do @(posedge core_clk); while (cpu_ready !== 1'b1);
        cpu.valid <= 1'b0;
        n = 0;
        do begin @(posedge core_clk); n++; end while (cpu_rvalid !== 1'b1 && n < 40);
        check("latency", lat, n);
        check("cpu_rdata", {a[31:2], 2'b00}, cpu_rdata);
        repeat (4) @(posedge core_clk);
    endtask : fetch
    task automatic t_regs;
        reg_acc(flash_cache_pkg::OFF_CTRL, 0, 0, flash_cache_pkg::CTRL_RESET);
        reg_acc(flash_cache_pkg::OFF_TAG, 0, 0, 0);
        reg_acc(flash_cache_pkg::OFF_CTRL, 1, 32'hFFFF_FFFF, 0);
        reg_acc(flash_cache_pkg::OFF_CTRL, 0, 0, flash_cache_pkg::CTRL_WMASK);
        reg_acc(8'h10, 0, 0, 0);
        reg_acc(flash_cache_pkg::OFF_CTRL, 1, 32'h0000_0001, 0);
    endtask : t_regs
    task automatic t_cache;
        fetch(32'h0000_0104, 1, 1, 3);
        fetch(32'h0000_0108, 1, 1, 1);
        reg_acc(flash_cache_pkg::OFF_CTRL, 1, 32'h0000_0011, 0);
        fetch(32'h0000_0200, 1, 1, 3);
        fetch(32'h0000_0214, 1, 1, 1);
        fetch(32'h0000_0600, 0, 1, 3);
        check("flash_rd", 0, flash_rd);
        reg_acc(flash_cache_pkg::OFF_CTRL, 1, 32'h0000_0021, 0);
        fetch(32'h0000_0300, 1, 0, 3);
        fetch(32'h0000_0310, 1, 0, 1);
        fetch(32'h0000_0310, 1, 1, 3);
    endtask : t_cache
    task automatic t_power;
        flash_write_done <= 1'b1;
        @(posedge core_clk);
        flash_write_done <= 1'b0;
        fetch(32'h0000_0104, 1, 1, 3);
        flash_prog_busy <= 1'b1;
        repeat (2) @(posedge core_clk);
        check("cpu_ready", 0, cpu_ready);
        flash_prog_busy <= 1'b0;
        sleep_req <= 1'b1;
        repeat (17) @(posedge core_clk);
        check("clk_stop_ok", 1, clk_stop_ok);
        sleep_req <= 1'b0;
        idle_req <= 1'b1;
        fetch(32'h0000_0700, 1, 1, 3);
        check("clk_stop_ok", 1, clk_stop_ok);
        idle_req <= 1'b0;
    endtask : t_power
    task automatic conclude;
        if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_regs;
        t_cache;
        t_power;
        conclude;
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        fails++;
        conclude;
    end
endmodule : flash_prefetch_cache_control_tb_top
`default_nettype wire
